// [verilog/rms_pkg.sv]
// Purpose: constants and types shared by the restore mode sequencer
// Assumes: 20 MHz device clock, pins already synchronous to it
// Notes: times are kept in their own unit; cycle counts are derived
package rms_pkg;

   localparam int unsigned CLK_KHZ = 20000;
   localparam int unsigned ENTRY_HOLD_MS = 500;
   localparam int unsigned CLEAR_HOLD_MS = 3000;
   localparam int unsigned LEGACY_PULSE_MS = 250;
   // least times round up; whole kHz makes each product exact
   localparam int unsigned ENTRY_HOLD_CYCLES = ENTRY_HOLD_MS * CLK_KHZ;
   localparam int unsigned CLEAR_HOLD_CYCLES = CLEAR_HOLD_MS * CLK_KHZ;
   localparam int unsigned LEGACY_PULSE_CYCLES = LEGACY_PULSE_MS * CLK_KHZ;

   localparam int unsigned TIMER_W = 32;
   localparam int unsigned BAUD_SEL_W = 2;
   localparam int unsigned VERSION_W = 16;
   // select code that the serial port decodes as 9600 baud
   localparam logic [BAUD_SEL_W-1:0] RESTORE_BAUD_SEL = 2'h0;
   localparam logic [VERSION_W-1:0] FW_VERSION_DEFAULT = 16'h0000;

   typedef enum logic [2:0] {
      ST_ARM,
      ST_NORMAL,
      ST_LEGACY_HOLD,
      ST_RESTORE_IDLE,
      ST_RESTORE_HOLD,
      ST_RESTORE_ARMED
   } rms_state_t;

   typedef struct packed {
      logic beep;
      logic erase;
      logic speakVersion;
   } rms_action_t;

   localparam rms_action_t ACTION_NONE = '{beep: 1'b0, erase: 1'b0, speakVersion: 1'b0};

endpackage : rms_pkg

// [verilog/rms_hold_timer.sv]
// Purpose: saturating counter of standby low time in clock cycles
// Assumes: run and clear come from the same clock domain
// Notes: count is registered; clear wins over run
`timescale 1ns/1ps
`default_nettype none
module rms_hold_timer #(
   parameter int unsigned WIDTH = 32
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic run,
   output logic [WIDTH-1:0] count
);

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;
   wire logic atMax = &count_q;

   assign count_d = clear ? '0 : ((run && !atMax) ? count_q + 1'b1 : count_q);
   assign count = count_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   if (WIDTH < 2) begin : gBadWidth
      $error("hold timer width too small");
   end

endmodule : rms_hold_timer
`default_nettype wire

// [verilog/rms_restore_sequencer.sv]
// Purpose: restore mode entry and standby pulse decoding
// Assumes: rst_n is the device reset pin; standby is synchronous, active low
// Notes: action pulses last one cycle; audio and flash units act on them
`timescale 1ns/1ps
`default_nettype none
module rms_restore_sequencer
   import rms_pkg::*;
#(
   parameter int unsigned ENTRY_CYCLES = ENTRY_HOLD_CYCLES,
   parameter int unsigned CLEAR_CYCLES = CLEAR_HOLD_CYCLES,
   parameter int unsigned LEGACY_CYCLES = LEGACY_PULSE_CYCLES,
   parameter bit LEGACY_FIRMWARE = 1'b0,
   parameter logic [VERSION_W-1:0] FW_VERSION = FW_VERSION_DEFAULT
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic standbyRequest_n,
   input wire logic [BAUD_SEL_W-1:0] baudRateSelectPins,
   input wire logic engineIdle,
   input wire logic versionQuery,
   output logic restoreMode,
   output logic imageLoadEnable,
   output logic [BAUD_SEL_W-1:0] baudSelect,
   output rms_action_t action,
   output logic versionValid,
   output logic [VERSION_W-1:0] versionWord
);

   localparam logic [TIMER_W-1:0] ENTRY_T = ENTRY_CYCLES[TIMER_W-1:0];
   localparam logic [TIMER_W-1:0] CLEAR_T = CLEAR_CYCLES[TIMER_W-1:0];
   localparam logic [TIMER_W-1:0] LEGACY_T = LEGACY_CYCLES[TIMER_W-1:0];

   rms_state_t state_q;
   rms_state_t state_d;
   rms_action_t action_q;
   rms_action_t action_d;
   logic restore_q;
   logic [BAUD_SEL_W-1:0] baud_q;
   logic versionValid_q;
   logic [VERSION_W-1:0] versionWord_q;
   logic [TIMER_W-1:0] lowCount;

   wire logic standbyLow = !standbyRequest_n;
   wire logic entryHeld = lowCount >= ENTRY_T;
   wire logic clearHeld = lowCount >= CLEAR_T;
   wire logic legacyShort = lowCount < LEGACY_T;
   wire logic restore_d = (state_d == ST_RESTORE_IDLE) || (state_d == ST_RESTORE_HOLD)
                          || (state_d == ST_RESTORE_ARMED);
   wire logic [BAUD_SEL_W-1:0] baud_d = restore_d ? RESTORE_BAUD_SEL : baudRateSelectPins;

   // low time of standby; cleared whenever the pin is high
   rms_hold_timer #(
      .WIDTH(TIMER_W)
   ) uTimer (
      .clk(clk),
      .rst_n(rst_n),
      .clear(standbyRequest_n),
      .run(standbyLow),
      .count(lowCount)
   );

   always_comb begin
      state_d = state_q;
      action_d = ACTION_NONE;
      case (state_q)
         ST_ARM: begin
            // reset released (or power applied) with standby held low
            if (standbyRequest_n) begin
               if (entryHeld) begin
                  state_d = ST_RESTORE_IDLE;
                  action_d.beep = 1'b1;
               end else begin
                  state_d = ST_NORMAL;
               end
            end
         end
         ST_NORMAL: begin
            if (LEGACY_FIRMWARE && engineIdle && standbyLow) begin
               state_d = ST_LEGACY_HOLD;
            end
         end
         ST_LEGACY_HOLD: begin
            if (standbyRequest_n) begin
               state_d = ST_NORMAL;
               if (legacyShort) begin
                  action_d.erase = 1'b1;
                  action_d.speakVersion = 1'b1;
               end
            end
         end
         ST_RESTORE_IDLE: begin
            if (standbyLow) begin
               state_d = ST_RESTORE_HOLD;
            end
         end
         ST_RESTORE_HOLD: begin
            if (standbyRequest_n) begin
               state_d = ST_RESTORE_IDLE;
               action_d.speakVersion = 1'b1;
            end else if (clearHeld) begin
               state_d = ST_RESTORE_ARMED;
               action_d.beep = 1'b1;
            end
         end
         ST_RESTORE_ARMED: begin
            if (standbyRequest_n) begin
               state_d = ST_RESTORE_IDLE;
               action_d.erase = 1'b1;
               action_d.speakVersion = 1'b1;
            end
         end
         default: begin
            state_d = ST_NORMAL;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_ARM;
         action_q <= ACTION_NONE;
         restore_q <= 1'b0;
         baud_q <= RESTORE_BAUD_SEL;
      end else begin
         state_q <= state_d;
         action_q <= action_d;
         restore_q <= restore_d;
         baud_q <= baud_d;
      end
   end

   // chipset id query answers with the firmware version
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         versionValid_q <= 1'b0;
         versionWord_q <= '0;
      end else begin
         versionValid_q <= versionQuery;
         versionWord_q <= versionQuery ? FW_VERSION : versionWord_q;
      end
   end

   assign restoreMode = restore_q;
   assign imageLoadEnable = restore_q;
   assign baudSelect = baud_q;
   assign action = action_q;
   assign versionValid = versionValid_q;
   assign versionWord = versionWord_q;

   if (CLEAR_CYCLES < 2 || ENTRY_CYCLES < 1 || LEGACY_CYCLES < 1) begin : gBadTimes
      $error("hold times must be at least one cycle");
   end
   if (LEGACY_CYCLES >= CLEAR_CYCLES) begin : gBadLegacy
      $error("legacy pulse must be shorter than clear hold");
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   entry_beep_a: assert property (
      (state_q == ST_ARM && standbyRequest_n && entryHeld)
      |=> restoreMode && action.beep && !action.erase)
      else $error("restore entry without beep");

   entry_short_a: assert property (
      (state_q == ST_ARM && standbyRequest_n && !entryHeld)
      |=> !restoreMode && !action.beep ##1 !restoreMode)
      else $error("restore entered on short hold");

   baud_forced_a: assert property (
      restoreMode |-> baudSelect == RESTORE_BAUD_SEL && imageLoadEnable)
      else $error("restore baud not forced");

   baud_follow_a: assert property (
      (!restore_d) |=> baudSelect == $past(baudRateSelectPins))
      else $error("baud select not following pins");

   clear_beep_a: assert property (
      (state_q == ST_RESTORE_HOLD && standbyLow && clearHeld)
      |=> action.beep ##1 !action.beep)
      else $error("no beep at clear threshold");

   clear_release_a: assert property (
      (state_q == ST_RESTORE_ARMED && standbyRequest_n)
      |=> action.erase && action.speakVersion && restoreMode)
      else $error("long release did not erase");

   short_pulse_a: assert property (
      (state_q == ST_RESTORE_HOLD && standbyRequest_n)
      |=> action.speakVersion && !action.erase)
      else $error("short pulse mishandled");

   // erase may only follow a long restore hold or a legacy short pulse
   erase_scope_a: assert property (
      action.erase |-> action.speakVersion && ($past(state_q) == ST_RESTORE_ARMED
                       || (LEGACY_FIRMWARE && $past(state_q) == ST_LEGACY_HOLD)))
      else $error("erase outside allowed modes");

   legacy_short_a: assert property (
      (state_q == ST_LEGACY_HOLD && standbyRequest_n && legacyShort)
      |=> action.erase && action.speakVersion && !restoreMode)
      else $error("legacy short pulse did not erase");

   version_reply_a: assert property (
      versionQuery |=> versionValid && versionWord == FW_VERSION)
      else $error("version query unanswered");

   timer_low_a: assert property (
      standbyRequest_n |=> lowCount == '0)
      else $error("low timer not cleared");

   // restore mode is left only through reset
   restore_hold_a: assert property (
      restoreMode |=> restoreMode && imageLoadEnable)
      else $error("restore mode left without reset");

   restore_entry_c: cover property (state_q == ST_ARM ##1 state_q == ST_RESTORE_IDLE);
   restore_clear_c: cover property (action.erase && restoreMode);
   restore_verify_c: cover property (action.speakVersion && !action.erase);
   normal_boot_c: cover property (state_q == ST_ARM ##1 state_q == ST_NORMAL);
   legacy_clear_c: cover property (action.erase && !restoreMode);

endmodule : rms_restore_sequencer
`default_nettype wire

// [tb/rms_button_model.sv]
// Purpose: pushbutton or host model driving the reset and standby pins
// Assumes: caller steps happen just after a rising clock edge
// Notes: pins change 2 ns after the edge
`timescale 1ns/1ps
`default_nettype none
module rms_button_model (
   input wire logic clk,
   output logic rst_n,
   output logic standbyRequest_n
);
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : cycles
   // reset with standby low, release, keep standby low, then raise
   task automatic enterSeq(input int lowCycles);
      rst_n = 1'b0;
      standbyRequest_n = 1'b0;
      cycles(3);
      rst_n = 1'b1;
      cycles(lowCycles);
      standbyRequest_n = 1'b1;
      cycles(2);
   endtask : enterSeq
   task automatic pulse(input int lowCycles);
      standbyRequest_n = 1'b0;
      cycles(lowCycles);
      standbyRequest_n = 1'b1;
      cycles(3);
   endtask : pulse
endmodule : rms_button_model
`default_nettype wire

// [tb/tb_restore_mode_sequencer.sv]
// Purpose: self-checking bench for the restore mode sequencer
// Assumes: short entry and clear counts, legacy idle pulse handling enabled
// Notes: results are queued by the driver and popped by a monitor
`timescale 1ns/1ps
`default_nettype none
module tb_restore_mode_sequencer;
   import rms_pkg::*;
   localparam logic [VERSION_W-1:0] FW = 16'h3A5C;
   logic clk, rst_n, standby_request_n, idle, query, restoreMode, imageLoadEnable, versionValid;
   logic [BAUD_SEL_W-1:0] pins, baudSelect;
   logic [VERSION_W-1:0] versionWord;
   rms_action_t action;
   int err_count, compares;
   int seed = 32'hdea2c340;
   logic [19:0] expQ[$];
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   rms_button_model btn (.clk(clk), .rst_n(rst_n), .standbyRequest_n(standby_request_n));
   rms_restore_sequencer #(.ENTRY_CYCLES(20), .CLEAR_CYCLES(60), .LEGACY_CYCLES(10),
      .LEGACY_FIRMWARE(1'b1), .FW_VERSION(FW)) dut (.clk(clk), .rst_n(rst_n),
      .standbyRequest_n(standby_request_n), .baudRateSelectPins(pins), .engineIdle(idle),
      .versionQuery(query), .restoreMode(restoreMode), .imageLoadEnable(imageLoadEnable),
      .baudSelect(baudSelect), .action(action), .versionValid(versionValid),
      .versionWord(versionWord));
   task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic expect_res(input rms_action_t a, input logic v, input logic [15:0] w);
      expQ.push_back({a, v, w});
   endtask : expect_res
   task automatic finish_test;
      chk("pending results", 20'h0, 20'(expQ.size()));
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   // monitor: each result pulse pops the oldest expectation; with none queued it is flagged as unexpected
   always @(negedge clk) begin
      if (action !== ACTION_NONE || versionValid !== 1'b0) begin
         if (expQ.size() == 0) chk("unexpected result", '0, {action, versionValid, versionWord});
         else chk("result", expQ.pop_front(), {action, versionValid, versionWord});
      end
   end
   initial begin
      repeat (2000) @(posedge clk);
      err_count++;
      $display("timeout");
      finish_test();
   end
   initial begin
      pins = '0;
      idle = 1'b0;
      query = 1'b0;
      btn.enterSeq(10);
      pins = BAUD_SEL_W'($random(seed));
      btn.cycles(2);
      chk("baudSelect", 20'(pins), 20'(baudSelect));
      chk("restoreMode", 20'h0, 20'(restoreMode));
      btn.pulse(5);
      expect_res('{beep: 1'b0, erase: 1'b1, speakVersion: 1'b1}, 1'b0, 16'h0000);
      idle = 1'b1;
      btn.pulse(5);
      btn.pulse(12);
      $display("test refused entry done");
      expect_res('{beep: 1'b1, erase: 1'b0, speakVersion: 1'b0}, 1'b0, 16'h0000);
      btn.enterSeq(25);
      chk("restoreMode", 20'h1, 20'(restoreMode));
      chk("imageLoadEnable", 20'h1, 20'(imageLoadEnable));
      pins = BAUD_SEL_W'($random(seed)) | 2'h1;
      idle = 1'($random(seed));
      btn.cycles(2);
      chk("baudSelect", 20'(RESTORE_BAUD_SEL), 20'(baudSelect));
      $display("test entry done");
      expect_res('{beep: 1'b0, erase: 1'b0, speakVersion: 1'b1}, 1'b0, 16'h0000);
      btn.pulse(1);
      expect_res('{beep: 1'b0, erase: 1'b0, speakVersion: 1'b1}, 1'b0, 16'h0000);
      btn.pulse(59);
      $display("test short pulse done");
      expect_res('{beep: 1'b1, erase: 1'b0, speakVersion: 1'b0}, 1'b0, 16'h0000);
      expect_res('{beep: 1'b0, erase: 1'b1, speakVersion: 1'b1}, 1'b0, 16'h0000);
      btn.pulse(62);
      $display("test long hold done");
      expect_res(ACTION_NONE, 1'b1, FW);
      expect_res(ACTION_NONE, 1'b1, FW);
      query = 1'b1;
      btn.cycles(2);
      query = 1'b0;
      btn.cycles(3);
      chk("restoreMode", 20'h1, 20'(restoreMode));
      $display("test version query done");
      finish_test();
   end
endmodule : tb_restore_mode_sequencer
`default_nettype wire
